//--- verilog/raos_host.sv
// Host end: AXI4-Lite registers, serial frame generator, result capture
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module raos_host #(
  parameter int SETTLE_CYCLES = raos_pkg::POWERUP_CYCLES,
  parameter int SCLK_HALF = raos_pkg::SCLK_HALF_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [raos_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [raos_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  raos_link_if.host link
);
  localparam int SET_W = $clog2(SETTLE_CYCLES + 1);

  // Device sees our edges three cycles late and we see its data two more
  generate
    if (SCLK_HALF < 8 || SCLK_HALF > 255 || SETTLE_CYCLES < 1) begin : g_bad_param
      $error("raos_host: SCLK_HALF must lie in 8..255, SETTLE_CYCLES >= 1");
    end
  endgenerate

  typedef enum logic [1:0] {F_IDLE, F_SHIFT, F_GAP} raos_frame_e;

  // ==========================================================
  // Input synchronisers and power-up settling
  logic [1:0] sdo_a_sync;
  logic [1:0] sdo_b_sync;
  logic [SET_W-1:0] settle_cnt;
  logic settled;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sdo_a_sync <= 2'h0;
      sdo_b_sync <= 2'h0;
      settle_cnt <= SET_W'(SETTLE_CYCLES);
      settled <= 1'b0;
    end else begin
      sdo_a_sync <= {sdo_a_sync[0], link.sdo_a};
      sdo_b_sync <= {sdo_b_sync[0], link.sdo_b};
      settle_cnt <= (settle_cnt == '0) ? settle_cnt : settle_cnt - SET_W'(1);
      settled <= (settle_cnt == '0);
    end
  end

  // ==========================================================
  // Frame generator
  raos_frame_e state, next_state;
  logic [7:0] half_cnt, next_half_cnt;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic cs_n, next_cs_n, sclk, next_sclk, sdi, next_sdi;
  logic [15:0] tx, next_tx, cmd_word, next_cmd_word;
  logic [17:0] rx_a, next_rx_a, rx_b, next_rx_b;
  logic frame_wide, next_frame_wide, last_wide, next_last_wide;
  logic [9:0] shadow, next_shadow;
  logic [31:0] res_a, next_res_a, res_b, next_res_b;
  logic start;
  logic [15:0] start_word;

  // Length follows the configuration this host last wrote
  always_comb begin
    next_state = state;
    next_half_cnt = half_cnt;
    next_bit_cnt = bit_cnt;
    next_cs_n = cs_n;
    next_sclk = sclk;
    next_sdi = sdi;
    next_tx = tx;
    next_cmd_word = cmd_word;
    next_rx_a = rx_a;
    next_rx_b = rx_b;
    next_frame_wide = frame_wide;
    next_last_wide = last_wide;
    next_shadow = shadow;
    next_res_a = res_a;
    next_res_b = res_b;
    unique case (state)
      F_IDLE: begin
        if (start) begin
          next_state = F_SHIFT;
          next_cs_n = 1'b0;
          next_sdi = start_word[15];
          next_tx = {start_word[14:0], 1'b0};
          next_cmd_word = start_word;
          next_half_cnt = 8'(SCLK_HALF);
          next_bit_cnt = '0;
          next_rx_a = '0;
          next_rx_b = '0;
          next_frame_wide = shadow[raos_pkg::CFG_AVG_EN] && shadow[raos_pkg::CFG_BOOST] &&
            shadow[8:6] != raos_pkg::RATIO_OFF && shadow[8:6] <= raos_pkg::RATIO_8;
        end
      end
      F_SHIFT: begin
        next_half_cnt = half_cnt - 8'h01;
        if (half_cnt == 8'h01) begin
          next_half_cnt = 8'(SCLK_HALF);
          next_sclk = ~sclk;
          if (!sclk) begin
            next_rx_a = {rx_a[16:0], sdo_a_sync[1]};
            next_rx_b = {rx_b[16:0], sdo_b_sync[1]};
            next_bit_cnt = bit_cnt + 5'h01;
          end else if (bit_cnt == (frame_wide ? 5'h12 : 5'h10)) begin
            next_state = F_GAP;
            next_cs_n = 1'b1;
            next_sdi = 1'b0;
            next_half_cnt = 8'(raos_pkg::QUIET_CYCLES);
            if (settled) begin
              next_res_a = frame_wide ? 32'($signed(rx_a)) : 32'($signed(rx_a[15:0]));
              next_res_b = frame_wide ? 32'($signed(rx_b)) : 32'($signed(rx_b[15:0]));
              next_last_wide = frame_wide;
            end
            if (cmd_word[raos_pkg::CMD_HARD]) begin
              next_shadow = raos_pkg::CFG_RESET;
            end else if (!cmd_word[raos_pkg::CMD_SOFT] && cmd_word[raos_pkg::CMD_WRITE]) begin
              next_shadow = cmd_word[9:0];
            end
          end else begin
            next_sdi = tx[15];
            next_tx = {tx[14:0], 1'b0};
          end
        end
      end
      F_GAP: begin
        next_half_cnt = half_cnt - 8'h01;
        if (half_cnt == 8'h01) begin
          next_state = F_IDLE;
        end
      end
      default: next_state = F_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= F_IDLE;
      half_cnt <= 8'h00;
      bit_cnt <= 5'h00;
      cs_n <= 1'b1;
      sclk <= 1'b0;
      sdi <= 1'b0;
      tx <= 16'h0000;
      cmd_word <= 16'h0000;
      rx_a <= 18'h00000;
      rx_b <= 18'h00000;
      frame_wide <= 1'b0;
      last_wide <= 1'b0;
      shadow <= raos_pkg::CFG_RESET;
      res_a <= 32'h00000000;
      res_b <= 32'h00000000;
    end else begin
      state <= next_state;
      half_cnt <= next_half_cnt;
      bit_cnt <= next_bit_cnt;
      cs_n <= next_cs_n;
      sclk <= next_sclk;
      sdi <= next_sdi;
      tx <= next_tx;
      cmd_word <= next_cmd_word;
      rx_a <= next_rx_a;
      rx_b <= next_rx_b;
      frame_wide <= next_frame_wide;
      last_wide <= next_last_wide;
      shadow <= next_shadow;
      res_a <= next_res_a;
      res_b <= next_res_b;
    end
  end

  assign link.cs_n = cs_n;
  assign link.sclk = sclk;
  assign link.sdi = sdi;

  // ==========================================================
  // AXI4-Lite slave
  logic aw_got, next_aw_got, w_got, next_w_got;
  logic [raos_pkg::AXI_AW-1:0] aw_q, next_aw_q;
  logic [31:0] wd_q, next_wd_q;
  logic [3:0] ws_q, next_ws_q;
  logic next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // A command while a frame runs is refused with SLVERR
  always_comb begin
    next_aw_got = aw_got;
    next_aw_q = aw_q;
    next_w_got = w_got;
    next_wd_q = wd_q;
    next_ws_q = ws_q;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    start = 1'b0;
    start_word = wd_q[15:0];
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_aw_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_wd_q = s_axi_wdata;
      next_ws_q = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_got && w_got && !s_axi_bvalid) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = raos_pkg::RESP_SLVERR;
      if (aw_q == raos_pkg::ADDR_CMD && ws_q[1:0] == 2'h3 && state == F_IDLE) begin
        start = 1'b1;
        next_bresp = raos_pkg::RESP_OKAY;
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = raos_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        raos_pkg::ADDR_CMD: next_rdata = {16'h0000, cmd_word};
        raos_pkg::ADDR_STATUS: next_rdata = {29'h0, last_wide, settled, state != F_IDLE};
        raos_pkg::ADDR_RES_A: next_rdata = res_a;
        raos_pkg::ADDR_RES_B: next_rdata = res_b;
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = raos_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= '0;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_q <= next_aw_q;
      wd_q <= next_wd_q;
      ws_q <= next_ws_q;
      s_axi_awready <= !next_aw_got;
      s_axi_wready <= !next_w_got;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end
endmodule

//--- inc/raos_pkg.sv
// Shared constants for the rolling-average oversampler and its host controller
package raos_pkg;
  // ==========================================================
  // Converter and history
  localparam int CODE_W = 16;
  localparam int BOOST_EXTRA = 2;
  localparam int HIST_DEPTH = 8;

  // ==========================================================
  // First configuration register layout
  localparam int CFG_W = 10;
  localparam int CFG_AVG_EN = 9;
  localparam int CFG_RATIO_HI = 8;
  localparam int CFG_RATIO_LO = 6;
  localparam int CFG_BOOST = 2;
  localparam int CFG_REFERENCE_SELECT_BIT = 1;
  localparam logic [9:0] CFG_RESET = 10'h000;
  localparam logic [2:0] RATIO_OFF = 3'h0;
  localparam logic [2:0] RATIO_8 = 3'h3;

  // ==========================================================
  // Command word sent on the data-in pin
  localparam int CMD_W = 16;
  localparam int CMD_WRITE = 15;
  localparam int CMD_SOFT = 14;
  localparam int CMD_HARD = 13;

  // ==========================================================
  // Timing
  localparam int CLK_NS = 100;
  localparam int T_CONV_NS = 500;
  localparam int CONV_CYCLES = (T_CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_POWERUP_NS = 5000;
  localparam int POWERUP_CYCLES = (T_POWERUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_SCLK_HALF_NS = 800;
  localparam int SCLK_HALF_CYCLES = (T_SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_QUIET_NS = 400;
  localparam int QUIET_CYCLES = (T_QUIET_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // Host register map
  localparam int AXI_AW = 5;
  localparam logic [4:0] ADDR_CMD = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_RES_A = 5'h08;
  localparam logic [4:0] ADDR_RES_B = 5'h0c;
  localparam int ST_BUSY = 0;
  localparam int ST_SETTLED = 1;
  localparam int ST_WIDE = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- inc/raos_link_if.sv
// Serial link between the oversampling converter and its host
`timescale 1ns/1ps
interface raos_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo_a;
  logic sdo_b;
  modport device (input cs_n, input sclk, input sdi, output sdo_a, output sdo_b);
  modport host (output cs_n, output sclk, output sdi, input sdo_a, input sdo_b);
endinterface

//--- verilog/raos_device.sv
// Converter end: conversion timing, history buffers, rolling average, serial shift
`timescale 1ns/1ps
// Overview of operation
// - Average only when enabled and ratio valid
// - Host clears enable and ratio to stop
// - Sum newest n samples, divide by n
// - Ratios two, four, eight, or off
// - Averaging never clears stored samples
// - One output result per conversion
// - Default result width is sixteen bits
// - Boost bit adds output resolution
// - Only chip-select falling edge starts conversion
// - Finished conversion loads into history
// - History always holds eight entries
// - First conversion after reset fills history
// - Every conversion that does not fill history shifts it, regardless of mode
// - Mode changes act at once, no refill
// - Host chooses spacing of chip-select edges
// - Early frames cause no lasting harm
// - Host discards results before settling
// - Boost with averaging gives eighteen bits
// - Soft reset flushes history, keeps configuration
// - Results sent MSB first, twos complement
module raos_device #(
  parameter int CODE_W = raos_pkg::CODE_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  raos_link_if.device link,
  input wire logic [CODE_W-1:0] adc_a_code,
  input wire logic [CODE_W-1:0] adc_b_code,
  output logic conv_start,
  output logic result_valid,
  output logic [CODE_W+1:0] result_a,
  output logic [CODE_W+1:0] result_b,
  output logic [raos_pkg::CFG_W-1:0] cfg,
  output logic avg_active,
  output logic boost_active
);
  localparam int OUT_W = CODE_W + raos_pkg::BOOST_EXTRA;
  localparam int HIST = raos_pkg::HIST_DEPTH;
  localparam int SUM_W = CODE_W + 3;
  localparam int CNT_W = $clog2(raos_pkg::CONV_CYCLES + 1);
  localparam int RXC_W = $clog2(raos_pkg::CMD_W + 1);
  localparam int CFG_W = raos_pkg::CFG_W;

  generate
    if (CODE_W < 4 || CODE_W > 28) begin : g_bad_width
      $error("raos_device: CODE_W must lie in 4..28");
    end
  endgenerate

  // ==========================================================
  // Pin synchronisers
  logic [2:0] cs_sync;
  logic [2:0] sclk_sync;
  logic [1:0] sdi_sync;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  // Two flops before use; the third stage only serves edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_sync <= 3'h7;
      sclk_sync <= 3'h0;
      sdi_sync <= 2'h0;
    end else begin
      cs_sync <= {cs_sync[1:0], link.cs_n};
      sclk_sync <= {sclk_sync[1:0], link.sclk};
      sdi_sync <= {sdi_sync[0], link.sdi};
    end
  end

  // Edges seen on synchronised pins; clock edges count only inside a frame
  assign cs_fall = cs_sync[2] & ~cs_sync[1];
  assign cs_rise = ~cs_sync[2] & cs_sync[1];
  assign sclk_rise = ~sclk_sync[2] & sclk_sync[1] & ~cs_sync[1];
  assign sclk_fall = sclk_sync[2] & ~sclk_sync[1] & ~cs_sync[1];

  // ==========================================================
  // Conversion timing from the internal oscillator
  logic converting;
  logic next_converting;
  logic [CNT_W-1:0] conv_cnt;
  logic [CNT_W-1:0] next_conv_cnt;
  logic conv_done;
  logic next_conv_start;

  // A falling edge during a running conversion is ignored
  always_comb begin
    next_converting = converting;
    next_conv_cnt = conv_cnt;
    conv_done = 1'b0;
    next_conv_start = 1'b0;
    if (converting) begin
      if (conv_cnt == CNT_W'(1)) begin
        next_converting = 1'b0;
        conv_done = 1'b1;
      end else begin
        next_conv_cnt = conv_cnt - CNT_W'(1);
      end
    end else if (cs_fall) begin
      next_converting = 1'b1;
      next_conv_cnt = CNT_W'(raos_pkg::CONV_CYCLES);
      next_conv_start = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converting <= 1'b0;
      conv_cnt <= '0;
      conv_start <= 1'b0;
    end else begin
      converting <= next_converting;
      conv_cnt <= next_conv_cnt;
      conv_start <= next_conv_start;
    end
  end

  // ==========================================================
  // Averaging helpers
  logic [2:0] ratio;
  logic avg_on;
  logic [1:0] avg_lg;
  logic wide;

  function automatic logic cfg_avg(input logic [CFG_W-1:0] c);
    logic [2:0] r;
    r = c[raos_pkg::CFG_RATIO_HI:raos_pkg::CFG_RATIO_LO];
    cfg_avg = c[raos_pkg::CFG_AVG_EN] && r != raos_pkg::RATIO_OFF && r <= raos_pkg::RATIO_8;
  endfunction

  // Sum of the newest 2**lg entries, scaled to a left-aligned result image
  function automatic logic [OUT_W-1:0] form_result(
    input logic [HIST-1:0][CODE_W-1:0] h,
    input logic [1:0] lg,
    input logic wd
  );
    logic signed [SUM_W-1:0] sum;
    logic signed [SUM_W+1:0] scaled;
    int i;
    sum = '0;
    for (i = 0; i < HIST; i++) begin
      if (i < (1 << lg)) begin
        sum = sum + $signed({{3{h[i][CODE_W-1]}}, h[i]});
      end
    end
    if (wd) begin
      scaled = $signed({sum, 2'b00}) >>> lg;
      form_result = scaled[OUT_W-1:0];
    end else begin
      scaled = $signed({{2{sum[SUM_W-1]}}, sum}) >>> lg;
      form_result = {scaled[CODE_W-1:0], 2'b00};
    end
  endfunction

  // Invalid ratio codes fall back to plain pass-through
  assign ratio = cfg[raos_pkg::CFG_RATIO_HI:raos_pkg::CFG_RATIO_LO];
  assign avg_on = cfg_avg(cfg);
  assign avg_lg = avg_on ? ratio[1:0] : 2'h0;
  assign wide = avg_on & cfg[raos_pkg::CFG_BOOST];

  // ==========================================================
  // Frame receive and transmit shifters
  logic [OUT_W-1:0] shift_a;
  logic [OUT_W-1:0] shift_b;
  logic [OUT_W-1:0] next_shift_a;
  logic [OUT_W-1:0] next_shift_b;
  logic [raos_pkg::CMD_W-1:0] rx_word;
  logic [raos_pkg::CMD_W-1:0] next_rx_word;
  logic [RXC_W-1:0] rx_cnt;
  logic [RXC_W-1:0] next_rx_cnt;
  logic cmd_go;

  // Snapped at frame start, cleared at frame end; extra clocks ignored
  always_comb begin
    next_shift_a = shift_a;
    next_shift_b = shift_b;
    next_rx_word = rx_word;
    next_rx_cnt = rx_cnt;
    if (cs_fall) begin
      next_shift_a = result_a;
      next_shift_b = result_b;
      next_rx_cnt = '0;
    end else if (cs_rise) begin
      next_shift_a = '0;
      next_shift_b = '0;
    end else if (sclk_fall) begin
      next_shift_a = {shift_a[OUT_W-2:0], 1'b0};
      next_shift_b = {shift_b[OUT_W-2:0], 1'b0};
    end
    if (sclk_rise && rx_cnt != RXC_W'(raos_pkg::CMD_W)) begin
      next_rx_word = {rx_word[raos_pkg::CMD_W-2:0], sdi_sync[1]};
      next_rx_cnt = rx_cnt + RXC_W'(1);
    end
  end

  // Short frames carry no command, so stray early traffic only starts a conversion that loads history
  assign cmd_go = cs_rise && rx_cnt == RXC_W'(raos_pkg::CMD_W);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_a <= '0;
      shift_b <= '0;
      rx_word <= '0;
      rx_cnt <= '0;
    end else begin
      shift_a <= next_shift_a;
      shift_b <= next_shift_b;
      rx_word <= next_rx_word;
      rx_cnt <= next_rx_cnt;
    end
  end

  assign link.sdo_a = shift_a[OUT_W-1];
  assign link.sdo_b = shift_b[OUT_W-1];

  // ==========================================================
  // History buffers, results and configuration
  logic [HIST-1:0][CODE_W-1:0] hist_a;
  logic [HIST-1:0][CODE_W-1:0] hist_b;
  logic [HIST-1:0][CODE_W-1:0] next_hist_a;
  logic [HIST-1:0][CODE_W-1:0] next_hist_b;
  logic fill_pending;
  logic next_fill_pending;
  logic [CFG_W-1:0] next_cfg;
  logic [OUT_W-1:0] next_res_a;
  logic [OUT_W-1:0] next_res_b;
  logic next_valid;

  // Commands come after the conversion update so a flush always wins
  always_comb begin
    next_hist_a = hist_a;
    next_hist_b = hist_b;
    next_fill_pending = fill_pending;
    next_cfg = cfg;
    next_res_a = result_a;
    next_res_b = result_b;
    next_valid = 1'b0;
    if (conv_done) begin
      if (fill_pending) begin
        next_hist_a = {HIST{adc_a_code}};
        next_hist_b = {HIST{adc_b_code}};
      end else begin
        next_hist_a = {hist_a[HIST-2:0], adc_a_code};
        next_hist_b = {hist_b[HIST-2:0], adc_b_code};
      end
      next_res_a = form_result(next_hist_a, avg_lg, wide);
      next_res_b = form_result(next_hist_b, avg_lg, wide);
      next_valid = 1'b1;
      next_fill_pending = 1'b0;
    end
    if (cmd_go) begin
      if (rx_word[raos_pkg::CMD_HARD] || rx_word[raos_pkg::CMD_SOFT]) begin
        next_hist_a = '0;
        next_hist_b = '0;
        next_res_a = '0;
        next_res_b = '0;
        next_fill_pending = 1'b1;
        if (rx_word[raos_pkg::CMD_HARD]) begin
          next_cfg = raos_pkg::CFG_RESET;
        end
      end else if (rx_word[raos_pkg::CMD_WRITE]) begin
        next_cfg = rx_word[CFG_W-1:0];
        if (next_cfg[raos_pkg::CFG_REFERENCE_SELECT_BIT] != cfg[raos_pkg::CFG_REFERENCE_SELECT_BIT]) begin
          next_fill_pending = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hist_a <= '0;
      hist_b <= '0;
      fill_pending <= 1'b1;
      cfg <= raos_pkg::CFG_RESET;
      result_a <= '0;
      result_b <= '0;
      result_valid <= 1'b0;
      avg_active <= 1'b0;
      boost_active <= 1'b0;
    end else begin
      hist_a <= next_hist_a;
      hist_b <= next_hist_b;
      fill_pending <= next_fill_pending;
      cfg <= next_cfg;
      result_a <= next_res_a;
      result_b <= next_res_b;
      result_valid <= next_valid;
      avg_active <= cfg_avg(next_cfg);
      boost_active <= cfg_avg(next_cfg) & next_cfg[raos_pkg::CFG_BOOST];
    end
  end
endmodule

//--- tb/raos_properties.sv
// Link pacing and result format checks beside the serial link
`timescale 1ns/1ps
module raos_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdo_a,
  input wire logic sdo_b,
  input wire logic conv_start,
  input wire logic result_valid,
  input wire logic [17:0] result_a,
  input wire logic [17:0] result_b,
  input wire logic [9:0] cfg,
  input wire logic avg_active,
  input wire logic boost_active
);
  // ==========
  // Conversion pacing
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_start_on_fall: assert property ($fell(cs_n) |-> ##3 conv_start)
    else $error("missing conversion start");
  chk_start_cause: assert property (conv_start |-> $past(cs_n, 4) && !$past(cs_n, 3))
    else $error("conversion without chip-select fall");
  chk_one_result: assert property (conv_start |-> !result_valid [*5] ##1 result_valid)
    else $error("result not one per conversion");
  chk_result_cause: assert property (result_valid |-> $past(conv_start, 5))
    else $error("result without conversion");
  // ==========
  // Mode decode and wire format
  chk_avg_mode: assert property ($stable(cfg) |->
    avg_active == (cfg[9] && cfg[8:6] != 3'h0 && !cfg[8])) else $error("averaging mode wrong");
  chk_boost_mode: assert property ($stable(cfg) |->
    boost_active == (avg_active && cfg[2])) else $error("boost mode wrong");
  chk_pad_short: assert property (result_valid && !boost_active |->
    result_a[1:0] == 2'h0 && result_b[1:0] == 2'h0) else $error("short result not padded");
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock outside frame");
  chk_sdo_idle: assert property (cs_n [*8] |-> !sdo_a && !sdo_b)
    else $error("data lines not idle");
endmodule

//--- tb/test_rolling_average_oversampler.sv
// Self-checking bench: host and device joined over the serial link
`timescale 1ns/1ps
module test_rolling_average_oversampler;
  logic aclk;
  logic aresetn = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, conv_start, result_valid;
  logic avg_active, boost_active;
  logic [1:0] bresp, rresp;
  logic [15:0] adc_a = 16'h0000, adc_b = 16'h0000;
  logic [17:0] res_a, res_b, ea, eb, prev;
  logic [9:0] cfg, cfg_m;
  int hist [2][8];
  bit fill, wide;
  int n_fail, comparisons, cycles;
  raos_link_if raos_link_if_inst ();
  raos_device raos_device_inst (.aclk(aclk), .aresetn(aresetn), .link(raos_link_if_inst),
    .adc_a_code(adc_a), .adc_b_code(adc_b), .conv_start(conv_start),
    .result_valid(result_valid), .result_a(res_a), .result_b(res_b), .cfg(cfg),
    .avg_active(avg_active), .boost_active(boost_active));
  raos_host #(.SETTLE_CYCLES(5)) raos_host_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link(raos_link_if_inst));
  raos_properties raos_properties_inst (.aclk(aclk), .aresetn(aresetn),
    .cs_n(raos_link_if_inst.cs_n), .sclk(raos_link_if_inst.sclk),
    .sdo_a(raos_link_if_inst.sdo_a), .sdo_b(raos_link_if_inst.sdo_b),
    .conv_start(conv_start), .result_valid(result_valid), .result_a(res_a),
    .result_b(res_b), .cfg(cfg), .avg_active(avg_active), .boost_active(boost_active));
  // ==========
  // Clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end
  // ==========
  // Bus tasks: sampled at the falling edge, driven at the rising one
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic [2:0] hs;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      hs = {awvalid & awready, wvalid & wready, bvalid & bready};
      if (hs[0]) r = bresp;
      @(posedge aclk);
      if (hs[2]) awvalid <= 1'b0;
      if (hs[1]) wvalid <= 1'b0;
      if (hs[0]) bready <= 1'b0;
    end while (awvalid || wvalid || bready);
  endtask
  task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic [1:0] hs;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      hs = {arvalid & arready, rvalid & rready};
      if (hs[0]) {d, r} = {rdata, rresp};
      @(posedge aclk);
      if (hs[1]) arvalid <= 1'b0;
      if (hs[0]) rready <= 1'b0;
    end while (arvalid || rready);
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ==========
  // Floor of sum over n, four times finer when boosted
  function automatic logic [17:0] image(int ch);
    int lg, sum;
    lg = (cfg_m[9] && cfg_m[8:6] != 3'h0 && !cfg_m[8]) ? int'(cfg_m[7:6]) : 0;
    sum = 0;
    for (int i = 0; i < (1 << lg); i++) sum += hist[ch][i];
    wide = lg != 0 && cfg_m[2];
    if (wide) return 18'((sum * 4) >>> lg);
    return 18'((sum >>> lg) * 4);
  endfunction
  // One frame: convert a code pair, then apply the command at frame end
  task automatic frame(input logic [15:0] cmd, input int code);
    logic [31:0] st, d;
    logic [1:0] r;
    adc_a <= 16'(code);
    adc_b <= 16'(-code);
    axi_write(raos_pkg::ADDR_CMD, {16'h0000, cmd}, r);
    st = 32'h1;
    for (int t = 0; t < 300 && st[0]; t++) axi_read(raos_pkg::ADDR_STATUS, st, r);
    repeat (8) @(posedge aclk);
    for (int c = 0; c < 2; c++) begin
      for (int i = 7; i > 0; i--) hist[c][i] = fill ? (c ? -code : code) : hist[c][i-1];
      hist[c][0] = c ? -code : code;
    end
    fill = 1'b0;
    {ea, eb} = {image(0), image(1)};
    axi_read(raos_pkg::ADDR_RES_A, d, r);
    check("wire a", wide ? {{14{prev[17]}}, prev} : {{16{prev[17]}}, prev[17:2]}, d);
    if (cmd[13]) cfg_m = 10'h000;
    else if (cmd[15]) fill |= cmd[1] != cfg_m[1];
    if (!cmd[13] && cmd[15]) cfg_m = cmd[9:0];
    fill |= cmd[13] | cmd[14];
    if (cmd[13] | cmd[14]) {ea, eb} = 36'h0;
    check("result a", 32'(ea), 32'(res_a));
    check("result b", 32'(eb), 32'(res_b));
    check("cfg", 32'(cfg_m), 32'(cfg));
    prev = ea;
  endtask
  // ==========
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    fill = 1'b1;
    cfg_m = 10'h000;
    prev = 18'h0;
    @(posedge aclk);
    axi_read(5'h10, d, r);
    check("unmapped rresp", 32'(r), 32'(raos_pkg::RESP_SLVERR));
    axi_write(raos_pkg::ADDR_STATUS, 32'h1, r);
    check("status bresp", 32'(r), 32'(raos_pkg::RESP_SLVERR));
    axi_read(raos_pkg::ADDR_STATUS, d, r);
    check("settled", 32'(d[raos_pkg::ST_SETTLED]), 32'h1);
    foreach (hist[c, i]) hist[c][i] = 0;
    frame(16'h0000, 100);
    frame(16'h82c0, 200);
    frame(16'h0000, 300);
    frame(16'h8240, -50);
    frame(16'h8280, 10);
    frame(16'h82c4, 7);
    frame(16'h8300, 1);
    frame(16'h8002, 5);
    frame(16'h82c2, 40);
    frame(16'h0000, 80);
    frame(16'h4000, 16);
    frame(16'h0000, 24);
    frame(16'h2000, 32);
    frame(16'h8000, -3);
    results();
  end
  task automatic results();
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
endmodule
